// File: rtl/sci_core.v
// serial interface core: AXI4-Lite registers, baud divisor, transmitter, gated receiver
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_core (
	input  wire        sys_clk_in,            // clock, 250 MHz
	input  wire        rst_in,                // async reset, high
	input  wire [17:0] s_axi_awaddr_in,       // write address
	input  wire        s_axi_awvalid_in,      // write address valid
	output wire        s_axi_awready_out,     // write address ready
	input  wire [31:0] s_axi_wdata_in,        // write data
	input  wire [3:0]  s_axi_wstrb_in,        // write strobes
	input  wire        s_axi_wvalid_in,       // write data valid
	output wire        s_axi_wready_out,      // write data ready
	output reg  [1:0]  s_axi_bresp_out,       // write response
	output reg         s_axi_bvalid_out,      // write response valid
	input  wire        s_axi_bready_in,       // write response ready
	input  wire [17:0] s_axi_araddr_in,       // read address
	input  wire        s_axi_arvalid_in,      // read address valid
	output wire        s_axi_arready_out,     // read address ready
	output reg  [31:0] s_axi_rdata_out,       // read data
	output reg  [1:0]  s_axi_rresp_out,       // read response
	output reg         s_axi_rvalid_out,      // read data valid
	input  wire        s_axi_rready_in,       // read data ready
	input  wire        serial_receive_pin_in, // serial input, idle high
	output reg         serial_transmit_pin_out, // serial output, idle high
	output wire        irq_out                // level interrupt
);
	localparam T_IDLE = 1'b0;
	localparam T_BUSY = 1'b1;

	// register state
	reg  [7:0]  serial_control_one_r;
	reg  [7:0]  baud_divisor_high_r;
	reg  [7:0]  baud_divisor_low_r;
	reg  [7:0]  irq_status_r;
	reg  [7:0]  irq_mask_r;
	reg  [7:0]  receive_buffer_r;
	reg         receive_ready_flag_r;
	reg         break_detect_flag_r;
	reg         framing_error_flag_r;
	reg         overrun_flag_r;
	reg  [7:0]  transmit_buffer_r;
	reg         tx_full_r;
	reg         tx_armed_r;
	reg         tx_state_r;
	reg  [9:0]  tx_sh_r;
	reg  [3:0]  tx_left_r;
	reg  [2:0]  tx_phase_r;
	// bus state
	reg         aw_hold_r;
	reg         w_hold_r;
	reg  [15:0] aw_idx_r;
	reg  [7:0]  w_byte_r;
	reg         w_lane_r;
	// combinational
	wire [15:0] baud_divisor_value;
	wire        tick;
	wire        rx_done;
	wire [7:0]  rx_data;
	wire        rx_addr;
	wire        rx_ferr;
	wire        rx_brk;
	wire        rx_take;
	wire        do_write;
	wire        ar_take;
	wire [15:0] ar_idx;
	wire        wr_ctl;
	wire        wr_txd;
	wire        wr_irq;
	wire        tx_load;
	wire        parity_error_flag;
	wire        rx_error;
	wire [7:0]  status_word;
	wire [7:0]  irq_events;
	reg  [7:0]  rd_val;
	reg         rd_ok;

	wire receiver_enable     = serial_control_one_r[`CTL_RX_ENABLE];
	wire transmitter_enable  = serial_control_one_r[`CTL_TX_ENABLE];
	wire rx_sleep            = serial_control_one_r[`CTL_SLEEP];
	wire transmit_wake_select = serial_control_one_r[`CTL_TX_WAKE];
	wire addr_mode           = serial_control_one_r[`CTL_ADDR_MODE];

	// the divisor is a pure concatenation; the counter picks it up at its next reload
	assign baud_divisor_value = {baud_divisor_high_r, baud_divisor_low_r};

	baud_gen u_baud (
		.clk_in     (sys_clk_in),
		.rst_in     (rst_in),
		.divisor_in (baud_divisor_value),
		.tick_out   (tick)
	);

	// shifter has no enable input, so a frame begun while disabled is still completed
	sci_rx_shift u_rx (
		.clk_in      (sys_clk_in),
		.rst_in      (rst_in),
		.tick_in     (tick),
		.rxd_in      (serial_receive_pin_in),
		.nine_bit_in (addr_mode),
		.done_out    (rx_done),
		.data_out    (rx_data),
		.addr_out    (rx_addr),
		.ferr_out    (rx_ferr),
		.brk_out     (rx_brk)
	);

	// transfer to the buffer needs the enable at completion and, while asleep, an address frame
	assign rx_take = rx_done & receiver_enable & (~rx_sleep | rx_addr);

	// AXI4-Lite write channel: address and data latched separately, in either order
	assign s_axi_awready_out = ~aw_hold_r;
	assign s_axi_wready_out  = ~w_hold_r;
	assign do_write          = aw_hold_r & w_hold_r & ~s_axi_bvalid_out;
	assign wr_ctl = do_write & w_lane_r & (aw_idx_r == `IDX_CTL_ONE);
	assign wr_txd = do_write & w_lane_r & (aw_idx_r == `IDX_TX_DATA);
	assign wr_irq = do_write & w_lane_r & (aw_idx_r == `IDX_IRQ_STATUS);

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_hold_r        <= 1'b0;
			w_hold_r         <= 1'b0;
			aw_idx_r         <= 16'h0000;
			w_byte_r         <= 8'h00;
			w_lane_r         <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && !aw_hold_r) begin
				aw_hold_r <= 1'b1;
				aw_idx_r  <= s_axi_awaddr_in[17:2];
			end
			if (s_axi_wvalid_in && !w_hold_r) begin
				w_hold_r <= 1'b1;
				w_byte_r <= s_axi_wdata_in[7:0];
				w_lane_r <= s_axi_wstrb_in[0];
			end
			if (do_write) begin
				aw_hold_r        <= 1'b0;
				w_hold_r         <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				case (aw_idx_r)
					`IDX_CTL_ONE, `IDX_BAUD_HIGH, `IDX_BAUD_LOW, `IDX_STATUS, `IDX_RX_DATA,
					`IDX_TX_DATA, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: begin
						s_axi_bresp_out <= `RESP_OKAY;
					end
					default: begin
						s_axi_bresp_out <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// plain read/write registers; the sleep bit has only this one writer
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			serial_control_one_r <= `RST_CTL_ONE;
			baud_divisor_high_r  <= `RST_BAUD;
			baud_divisor_low_r   <= `RST_BAUD;
			irq_mask_r           <= `RST_IRQ_MASK;
		end else if (do_write && w_lane_r) begin
			case (aw_idx_r)
				`IDX_CTL_ONE:   serial_control_one_r <= w_byte_r;
				`IDX_BAUD_HIGH: baud_divisor_high_r  <= w_byte_r;
				`IDX_BAUD_LOW:  baud_divisor_low_r   <= w_byte_r;
				`IDX_IRQ_MASK:  irq_mask_r           <= w_byte_r;
				default: begin
				end
			endcase
		end
	end

	// AXI4-Lite read channel: one cycle from address taken to data valid
	assign s_axi_arready_out = ~s_axi_rvalid_out;
	assign ar_take           = s_axi_arvalid_in & ~s_axi_rvalid_out;
	assign ar_idx            = s_axi_araddr_in[17:2];

	assign parity_error_flag = 1'b0; // no parity in this frame format
	assign rx_error    = break_detect_flag_r | framing_error_flag_r | overrun_flag_r | parity_error_flag;
	assign status_word = {rx_error, parity_error_flag, break_detect_flag_r, framing_error_flag_r,
		overrun_flag_r, (tx_state_r == T_IDLE) & ~tx_full_r, ~tx_full_r, receive_ready_flag_r};

	always @* begin
		rd_val = 8'h00;
		rd_ok  = 1'b1;
		case (ar_idx)
			`IDX_CTL_ONE:    rd_val = serial_control_one_r;
			`IDX_BAUD_HIGH:  rd_val = baud_divisor_high_r;
			`IDX_BAUD_LOW:   rd_val = baud_divisor_low_r;
			`IDX_STATUS:     rd_val = status_word;
			`IDX_RX_DATA:    rd_val = receive_buffer_r;
			`IDX_TX_DATA:    rd_val = transmit_buffer_r;
			`IDX_IRQ_STATUS: rd_val = irq_status_r;
			`IDX_IRQ_MASK:   rd_val = irq_mask_r;
			default:         rd_ok  = 1'b0;
		endcase
	end

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h00000000;
			s_axi_rresp_out  <= `RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out  <= {24'h000000, rd_val};
			s_axi_rresp_out  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// receive buffer and its flags change only on an accepted transfer; reading data clears ready
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			receive_buffer_r     <= 8'h00;
			receive_ready_flag_r <= 1'b0;
			break_detect_flag_r  <= 1'b0;
			framing_error_flag_r <= 1'b0;
			overrun_flag_r       <= 1'b0;
		end else if (rx_take) begin
			receive_buffer_r     <= rx_data;
			receive_ready_flag_r <= 1'b1;
			break_detect_flag_r  <= rx_brk;
			framing_error_flag_r <= rx_ferr;
			overrun_flag_r       <= receive_ready_flag_r;
		end else if (ar_take && ar_idx == `IDX_RX_DATA) begin
			receive_ready_flag_r <= 1'b0;
		end
	end

	// a character is armed if written, or later found, with the transmitter enabled
	assign tx_load = (tx_state_r == T_IDLE) & tx_full_r & (tx_armed_r | transmitter_enable);

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			transmit_buffer_r <= 8'h00;
			tx_full_r         <= 1'b0;
			tx_armed_r        <= 1'b0;
		end else if (wr_txd) begin
			transmit_buffer_r <= w_byte_r;
			tx_full_r         <= 1'b1;
			tx_armed_r        <= transmitter_enable;
		end else if (tx_load) begin
			tx_full_r  <= 1'b0;
			tx_armed_r <= 1'b0;
		end
	end

	// transmit shifter: start, data, optional address bit, stop; a started frame always ends
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_state_r              <= T_IDLE;
			tx_sh_r                 <= 10'h3FF;
			tx_left_r               <= 4'h0;
			tx_phase_r              <= 3'h0;
			serial_transmit_pin_out <= 1'b1;
		end else begin
			case (tx_state_r)
				T_IDLE: begin
					serial_transmit_pin_out <= 1'b1; // mark level, no data
					if (tx_load) begin
						tx_state_r <= T_BUSY;
						tx_phase_r <= 3'h0;
						if (addr_mode) begin
							tx_sh_r   <= {1'b1, transmit_wake_select, transmit_buffer_r};
							tx_left_r <= 4'd10;
						end else begin
							tx_sh_r   <= {2'b11, transmit_buffer_r};
							tx_left_r <= 4'd9;
						end
						serial_transmit_pin_out <= 1'b0;
					end
				end
				T_BUSY: begin
					if (tick) begin
						tx_phase_r <= tx_phase_r + 3'h1;
						if (tx_phase_r == `TICKS_PER_BIT) begin
							if (tx_left_r == 4'h0) begin
								tx_state_r              <= T_IDLE;
								serial_transmit_pin_out <= 1'b1;
							end else begin
								serial_transmit_pin_out <= tx_sh_r[0];
								tx_sh_r                 <= {1'b1, tx_sh_r[9:1]};
								tx_left_r               <= tx_left_r - 4'h1;
							end
						end
					end
				end
				default: begin
					tx_state_r <= T_IDLE;
				end
			endcase
		end
	end

	// sticky interrupt status; a new event beats a write-one clear in the same cycle
	assign irq_events = {5'h00, rx_take & (rx_brk | rx_ferr | receive_ready_flag_r), tx_load, rx_take};

	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_status_r <= 8'h00;
		end else begin
			irq_status_r <= (irq_status_r & ~(wr_irq ? w_byte_r : 8'h00)) | irq_events;
		end
	end

	assign irq_out = |(irq_status_r & irq_mask_r);
endmodule

// File: rtl/sci_map.vh
// register map, field positions, reset values and timing counts of the serial interface
`ifndef SCI_MAP_VH
`define SCI_MAP_VH
`define IDX_CTL_ONE     16'h7060
`define IDX_BAUD_HIGH   16'h7052
`define IDX_BAUD_LOW    16'h7053
`define IDX_STATUS      16'h7061
`define IDX_RX_DATA     16'h7062
`define IDX_TX_DATA     16'h7063
`define IDX_IRQ_STATUS  16'h7064
`define IDX_IRQ_MASK    16'h7065
`define CTL_RX_ENABLE   0
`define CTL_TX_ENABLE   1
`define CTL_SLEEP       2
`define CTL_TX_WAKE     3
`define CTL_ADDR_MODE   4
`define ST_RX_READY     0
`define ST_TX_READY     1
`define ST_TX_EMPTY     2
`define ST_OVERRUN      3
`define ST_FRAMING      4
`define ST_BREAK        5
`define ST_PARITY       6
`define ST_RX_ERROR     7
`define IRQ_RX_CHAR     0
`define IRQ_TX_READY    1
`define IRQ_RX_ERR      2
`define RST_CTL_ONE     8'h00
`define RST_BAUD        8'h00
`define RST_IRQ_MASK    8'h00
`define TICKS_PER_BIT   3'h7
`define SAMPLE_PHASE    3'h3
`define ZERO_DIV_RELOAD 16'h0001
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: rtl/baud_gen.v
// baud down-counter producing one sample enable per divisor period
`timescale 1ns/1ps
`include "sci_map.vh"
module baud_gen (
	input  wire        clk_in,      // peripheral clock
	input  wire        rst_in,      // async reset, high
	input  wire [15:0] divisor_in,  // baud divisor value
	output reg         tick_out     // one-cycle sample enable
);
	reg  [15:0] count_r;
	wire [15:0] reload;

	// zero divisor still gives a two-clock period, so a bit lasts 16 clocks
	assign reload = (divisor_in == 16'h0000) ? `ZERO_DIV_RELOAD : divisor_in;

	// reload only at terminal count, so a new divisor never cuts a period short
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_r  <= 16'h0000;
			tick_out <= 1'b0;
		end else if (count_r == 16'h0000) begin
			count_r  <= reload;
			tick_out <= 1'b1;
		end else begin
			count_r  <= count_r - 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule

// File: rtl/sci_rx_shift.v
// receive shift register: assembles frames regardless of the enable bits
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_rx_shift (
	input  wire       clk_in,      // clock
	input  wire       rst_in,      // async reset, high
	input  wire       tick_in,     // sample enable, 8 per bit
	input  wire       rxd_in,      // serial line, idle high
	input  wire       nine_bit_in, // frame carries an address bit
	output reg        done_out,    // one-cycle pulse at stop sample
	output reg  [7:0] data_out,    // assembled character
	output reg        addr_out,    // address bit of the frame
	output reg        ferr_out,    // stop bit was low
	output reg        brk_out      // whole frame low and, in eight-bit mode, the last bit received in the previous frame low
);
	localparam S_IDLE  = 2'd0;
	localparam S_START = 2'd1;
	localparam S_DATA  = 2'd2;
	localparam S_STOP  = 2'd3;

	reg [1:0] state_r;
	reg [2:0] phase_r;
	reg [3:0] idx_r;
	reg [8:0] sh_r;
	wire [3:0] nbits;

	assign nbits = nine_bit_in ? 4'd9 : 4'd8;

	// frame sequencer, mid-bit sampling at phase 3
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r  <= S_IDLE;
			phase_r  <= 3'h0;
			idx_r    <= 4'h0;
			sh_r     <= 9'h000;
			done_out <= 1'b0;
			data_out <= 8'h00;
			addr_out <= 1'b0;
			ferr_out <= 1'b0;
			brk_out  <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (tick_in) begin
				phase_r <= phase_r + 3'h1;
				case (state_r)
					S_IDLE: begin
						phase_r <= 3'h0;
						if (!rxd_in) begin
							state_r <= S_START;
						end
					end
					S_START: begin
						if (phase_r == `SAMPLE_PHASE && rxd_in) begin
							state_r <= S_IDLE; // glitch, not a start bit
						end else if (phase_r == `TICKS_PER_BIT) begin
							state_r <= S_DATA;
							idx_r   <= 4'h0;
						end
					end
					S_DATA: begin
						if (phase_r == `SAMPLE_PHASE) begin
							sh_r  <= {rxd_in, sh_r[8:1]};
							idx_r <= idx_r + 4'h1;
						end else if (phase_r == `TICKS_PER_BIT && idx_r == nbits) begin
							state_r <= S_STOP;
						end
					end
					S_STOP: begin
						if (phase_r == `SAMPLE_PHASE) begin
							state_r  <= S_IDLE;
							done_out <= 1'b1;
							data_out <= nine_bit_in ? sh_r[7:0] : sh_r[8:1];
							addr_out <= nine_bit_in & sh_r[8];
							ferr_out <= ~rxd_in;
							brk_out  <= ~rxd_in & (sh_r == 9'h000);
						end
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// File: bench/sci_core_props.sv
// concurrent checks on the serial interface core ports
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_core_props (
	input wire        sys_clk_in,              // clock
	input wire        rst_in,                  // async reset, high
	input wire        s_axi_awvalid_in,        // write address valid
	input wire        s_axi_awready_out,       // write address ready
	input wire        s_axi_wvalid_in,         // write data valid
	input wire        s_axi_wready_out,        // write data ready
	input wire [1:0]  s_axi_bresp_out,         // write response
	input wire        s_axi_bvalid_out,        // write response valid
	input wire        s_axi_bready_in,         // write response ready
	input wire [17:0] s_axi_araddr_in,         // read address
	input wire        s_axi_arvalid_in,        // read address valid
	input wire        s_axi_arready_out,       // read address ready
	input wire [31:0] s_axi_rdata_out,         // read data
	input wire [1:0]  s_axi_rresp_out,         // read response
	input wire        s_axi_rvalid_out,        // read data valid
	input wire        s_axi_rready_in,         // read data ready
	input wire        serial_transmit_pin_out  // serial output
);
	wire [15:0] ridx;
	wire        rd_mapped;
	// decode of the read index, so the answer code can be tied to it
	assign ridx = s_axi_araddr_in[17:2];
	assign rd_mapped = (ridx == `IDX_BAUD_HIGH) || (ridx == `IDX_BAUD_LOW) ||
		(ridx >= `IDX_CTL_ONE && ridx <= `IDX_IRQ_MASK);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_write_answered: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
	a_aw_held_alone: assert property (s_axi_awvalid_in && s_axi_awready_out && !s_axi_wvalid_in
		|=> !s_axi_awready_out) else $error("second address taken");
	a_bresp_kept: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
	a_read_answered: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read not answered");
	a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
	a_rdata_kept: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	a_read_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out && !rd_mapped
		|=> s_axi_rresp_out == `RESP_SLVERR && s_axi_rdata_out == 32'h0) else $error("unmapped read accepted");
	a_byte_register: assert property (s_axi_arvalid_in && s_axi_arready_out && rd_mapped
		|=> s_axi_rresp_out == `RESP_OKAY && s_axi_rdata_out[31:8] == 24'h0) else $error("mapped read wrong");
	a_shortest_bit: assert property ($fell(serial_transmit_pin_out)
		|-> (!serial_transmit_pin_out) [*8]) else $error("low level too short");
	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_unmapped: cover property (s_axi_rvalid_out && s_axi_rresp_out == `RESP_SLVERR);
	c_frame: cover property ($fell(serial_transmit_pin_out));
endmodule
bind sci_core sci_core_props chk_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .serial_transmit_pin_out(serial_transmit_pin_out));

// File: bench/remote_node.sv
// remote serial node: sends frames to the core and decodes what the core transmits
`timescale 1ns/1ps
module remote_node (
	input  wire        clk_in,      // shared clock
	input  wire [31:0] bit_clks_in, // bit period in clocks
	input  wire        line_in,     // core transmit pin
	output reg         line_out,    // core receive pin, idle high
	output reg  [7:0]  got_out,     // last decoded character
	output reg  [31:0] frames_out   // decoded frame count
);
	reg [7:0] sh;
	integer   n;
	// the line rests at the mark level between frames
	initial begin
		line_out = 1'b1;
		got_out = 8'h00;
		frames_out = 32'h0;
		sh = 8'h00;
	end
	// start, eight data bits lsb first, optional address bit, stop
	task send(input [7:0] d, input a, input nine);
		begin
			line_out <= 1'b0;
			repeat (bit_clks_in) @(posedge clk_in);
			for (n = 0; n < 9; n = n + 1) begin
				if (n < 8 || nine) begin
					line_out <= (n < 8) ? d[n] : a;
					repeat (bit_clks_in) @(posedge clk_in);
				end
			end
			line_out <= 1'b1;
			repeat (bit_clks_in) @(posedge clk_in);
		end
	endtask
	// decoder samples mid-bit, so a start bit up to one tick short still lines up
	initial forever begin
		@(negedge line_in);
		repeat (bit_clks_in / 2) @(posedge clk_in);
		repeat (8) begin
			repeat (bit_clks_in) @(posedge clk_in);
			sh = {line_in, sh[7:1]};
		end
		repeat (bit_clks_in) @(posedge clk_in);
		got_out = sh;
		frames_out = frames_out + 1;
	end
endmodule

// File: bench/sci_rx_tx_enable_sleep_baud_bench.sv
// self-checking bench for the serial interface core
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_rx_tx_enable_sleep_baud_bench;
	reg         clk;
	reg         rst;
	reg  [17:0] awaddr;
	reg         awvalid;
	reg  [31:0] wdata;
	reg         wvalid;
	reg         bready;
	reg  [17:0] araddr;
	reg         arvalid;
	reg         rready;
	wire        awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, frames;
	wire [7:0]  got;
	reg  [31:0] rv, cnt, f0;
	reg  [1:0]  rs;
	reg  [15:0] dv;
	integer     mismatches, n_tests, bit_clks, i, k;
	sci_core dut_u (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.serial_receive_pin_in(rxd), .serial_transmit_pin_out(txd), .irq_out(irq));
	remote_node node_u (.clk_in(clk), .bit_clks_in(bit_clks), .line_in(txd), .line_out(rxd), .got_out(got),
		.frames_out(frames));
	task complete_run;
		begin
			$display("counts: mismatches=%0d n_tests=%0d", mismatches, n_tests);
			if (mismatches == 0 && n_tests > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e, input [255:0] m);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("mismatch at %0t: %0s got %h exp %h", $time, m, g, e);
			end
		end
	endtask
	task tick_bound;
		begin
			k = k + 1;
			if (k > 30000) begin
				$display("mismatch at %0t: wait ran out", $time);
				mismatches = mismatches + 1;
				complete_run;
			end
		end
	endtask
	// handshake state is sampled mid-cycle, then acted on right after the next rising edge
	task wr(input [15:0] idx, input [7:0] d);
		reg a, w, b, bb;
		begin
			@(posedge clk);
			awaddr <= {idx, 2'b00};
			awvalid <= 1'b1;
			wdata <= {24'h0, d};
			wvalid <= 1'b1;
			b = 0;
			bb = 0;
			k = 0;
			while (!(b && bb)) begin
				tick_bound;
				@(negedge clk);
				a = awvalid & awready;
				w = wvalid & wready;
				b = bvalid;
				bb = bready;
				rs = bresp;
				@(posedge clk);
				if (a)
					awvalid <= 1'b0;
				if (w)
					wvalid <= 1'b0;
				bready <= b & !bb; // raised late on purpose so the slave must hold its answer
			end
		end
	endtask
	task rd(input [15:0] idx);
		reg a, r, rr;
		begin
			@(posedge clk);
			araddr <= {idx, 2'b00};
			arvalid <= 1'b1;
			r = 0;
			rr = 0;
			k = 0;
			while (!(r && rr)) begin
				tick_bound;
				@(negedge clk);
				a = arvalid & arready;
				r = rvalid;
				rr = rready;
				rv = rdata;
				rs = rresp;
				@(posedge clk);
				if (a)
					arvalid <= 1'b0;
				rready <= r & !rr;
			end
		end
	endtask
	// counts falling edges until the pin shows v
	task wait_lvl(input v);
		begin
			cnt = 0;
			k = 0;
			while (txd !== v) begin
				tick_bound;
				@(negedge clk);
				cnt = cnt + 1;
			end
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = 0;
		mismatches = 0;
		n_tests = 0;
		bit_clks = 16;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// reset values and an unmapped place
		rd(`IDX_BAUD_HIGH);
		chk(rv, 32'h0, "baud high reset");
		rd(`IDX_BAUD_LOW);
		chk(rv, 32'h0, "baud low reset");
		rd(`IDX_CTL_ONE);
		chk(rv, 32'h0, "control reset");
		rd(16'h7000);
		chk(rs, `RESP_SLVERR, "unmapped read");
		wr(16'h7001, 8'hFF);
		chk(rs, `RESP_SLVERR, "unmapped write");
		// a one in bit 0 then a zero makes the bit-0 high time exactly one bit period
		wr(`IDX_CTL_ONE, 8'h02);
		for (i = 0; i < 3; i = i + 1) begin
			dv = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0002 : 16'h0100;
			bit_clks = (dv == 16'h0) ? 16 : 8 * (dv + 1);
			wr(`IDX_BAUD_HIGH, dv[15:8]);
			wr(`IDX_BAUD_LOW, dv[7:0]);
			wr(`IDX_TX_DATA, 8'h01);
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			wait_lvl(1'b0);
			chk(cnt, bit_clks, "bit period");
			repeat (bit_clks * 10) @(posedge clk);
			chk(got, 8'h01, "sent char");
		end
		wr(`IDX_BAUD_HIGH, 8'h00);
		wr(`IDX_BAUD_LOW, 8'h02);
		repeat (3000) @(posedge clk);
		bit_clks = 24;
		// disabled transmitter leaves the pin idle
		wr(`IDX_CTL_ONE, 8'h00);
		wr(`IDX_TX_DATA, 8'h55);
		rv = 0;
		repeat (400) begin
			@(negedge clk);
			if (txd !== 1'b1)
				rv = 1;
		end
		chk(rv, 32'h0, "pin moved while off");
		// two characters pending when the enable drops must both go out
		wr(`IDX_CTL_ONE, 8'h02);
		repeat (24 * 12) @(posedge clk);
		f0 = frames;
		wr(`IDX_TX_DATA, 8'hA5);
		wr(`IDX_TX_DATA, 8'h3C);
		wr(`IDX_CTL_ONE, 8'h00);
		repeat (24 * 25) @(posedge clk);
		chk(frames - f0, 32'h2, "frames after disable");
		chk(got, 8'h3C, "last char");
		// receiver off: nothing reaches buffer or interrupt
		wr(`IDX_IRQ_MASK, 8'h01);
		node_u.send(8'hC3, 1'b0, 1'b0);
		rd(`IDX_STATUS);
		chk(rv & 32'h1, 32'h0, "ready while off");
		chk(rv & 32'h6, 32'h6, "tx flags idle");
		chk(irq, 1'b0, "irq while off");
		// enable arrives mid-character; that character is kept
		fork
			node_u.send(8'h5A, 1'b0, 1'b0);
			begin
				repeat (100) @(posedge clk);
				wr(`IDX_CTL_ONE, 8'h01);
			end
		join
		repeat (30) @(posedge clk);
		rd(`IDX_STATUS);
		chk(rv & 32'h1, 32'h1, "ready after enable");
		chk(irq, 1'b1, "irq raised");
		wr(`IDX_IRQ_MASK, 8'h00);
		chk(irq, 1'b0, "irq masked");
		wr(`IDX_IRQ_MASK, 8'h01);
		chk(irq, 1'b1, "irq unmasked");
		wr(`IDX_IRQ_STATUS, 8'h01);
		chk(irq, 1'b0, "irq cleared");
		rd(`IDX_RX_DATA);
		chk(rv, 32'h5A, "char kept");
		// sleeping receiver ignores data frames, takes an address frame, stays asleep
		wr(`IDX_CTL_ONE, 8'h15);
		node_u.send(8'h77, 1'b0, 1'b1);
		repeat (30) @(posedge clk);
		rd(`IDX_STATUS);
		chk(rv & 32'h1, 32'h0, "data while asleep");
		node_u.send(8'h42, 1'b1, 1'b1);
		repeat (30) @(posedge clk);
		rd(`IDX_STATUS);
		chk(rv & 32'h1, 32'h1, "address while asleep");
		rd(`IDX_CTL_ONE);
		chk(rv, 32'h15, "sleep kept");
		rd(`IDX_RX_DATA);
		chk(rv, 32'h42, "address char");
		wr(`IDX_CTL_ONE, 8'h11);
		node_u.send(8'h33, 1'b0, 1'b1);
		repeat (30) @(posedge clk);
		rd(`IDX_RX_DATA);
		chk(rv, 32'h33, "awake data");
		// nine-bit transmit with the wake bit set; the node checks only the eight data bits
		wr(`IDX_CTL_ONE, 8'h1A);
		f0 = frames;
		wr(`IDX_TX_DATA, 8'h96);
		repeat (24 * 13) @(posedge clk);
		chk(frames - f0, 32'h1, "address mode frame");
		chk(got, 8'h96, "address mode char");
		complete_run;
	end
endmodule
